// [hw/serial_bcd_consts.svh]
// constants for the serial bcd up/down counter and stopwatch
`ifndef SERIAL_BCD_CONSTS_SVH
`define SERIAL_BCD_CONSTS_SVH

// ****************************************************************
// digit-serial counter
// ****************************************************************
`define DIGIT_COUNT     8
`define PLANE_COUNT     4
`define LAST_POS        3'h7
`define UP_STEP         4'h1
`define DOWN_STEP       4'hf
`define UP_LOAD         4'h0
`define DOWN_LOAD       4'h9

// ****************************************************************
// bit-serial stopwatch
// ****************************************************************
`define BIT_LEN         36
`define LAST_BIT        6'h23
`define DEC_LIMIT       4'h9
`define SIX_LIMIT       4'h5
`define TENS_SEC_DIGIT  4'h5
`define TENS_MIN_DIGIT  4'h7
`define SW_SHIFT_DIV    10

`endif

// [hw/serial_bcd_pkg.sv]
// types shared by the serial bcd counter
package serial_bcd_pkg;
    typedef enum logic [0:0] {
        VAR_DIGIT = 1'b0,
        VAR_BIT   = 1'b1
    } variant_t;
    typedef logic [3:0] bcd_t;
    typedef logic [6:0] seg_t;
endpackage : serial_bcd_pkg

// [hw/serial_bcd_updown_counter.sv]
// serial bcd up/down counter with multiplexed seven-segment drive
//
// Summary of operation
// R1 - four 8-bit recirculating planes hold one bit of each digit
// R2 - each leaving digit passes a 4-bit adder, result written back
// R3 - carry flag is preset as the least significant digit appears
// R4 - with carry set, add 1 counting up or 15 counting down
// R5 - result 10 becomes 0 up, 15 becomes 9 down; carry from sum
// R6 - sum bits one and three both high make a carry to next digit
// R7 - on correction load 0 up or 9 down instead of the sum
// R8 - modulo-8 position counter selects the matching display digit
// R9 - segment data decoded from the four plane outputs
// R10 - count input runs through 2-bit shift register; rising edge
// R11 - step request held until carry preset; shown as busy
// R12 - count edges come no faster than one eighth of shift rate
// R13 - bit-serial variant keeps nine digits in 36 bits, xor step
// R14 - bit-serial increment of the lowest digit takes 36 shifts
// R15 - tens-of-seconds and tens-of-minutes digits wrap modulo 6
// R16 - display store stops following the counter while stopped
// R17 - store digit latched into holding register every four shifts
// R18 - stopwatch shift clock is the oscillator divided by ten
// R19 - reset clears digits, carry, request, edge detector, position
// R20 - source keeps direction steady while busy is shown
`timescale 1ns/10ps
`include "serial_bcd_consts.svh"

module serial_bcd_updown_counter
    import serial_bcd_pkg::*;
#(
    parameter variant_t    VARIANT   = VAR_DIGIT,
    parameter int unsigned SHIFT_DIV = `SW_SHIFT_DIV
) (
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       count_in,
    input  wire logic       count_up,
    input  wire logic       stop,
    output logic            busy,
    output logic [7:0]      digit_sel_r,
    output seg_t            seg_r
);

    // ****************************************************************
    // shared decoding
    // ****************************************************************
    function automatic seg_t seg_decode(input bcd_t d);
        unique case (d)
            4'h0:    seg_decode = 7'h3f;
            4'h1:    seg_decode = 7'h06;
            4'h2:    seg_decode = 7'h5b;
            4'h3:    seg_decode = 7'h4f;
            4'h4:    seg_decode = 7'h66;
            4'h5:    seg_decode = 7'h6d;
            4'h6:    seg_decode = 7'h7d;
            4'h7:    seg_decode = 7'h07;
            4'h8:    seg_decode = 7'h7f;
            4'h9:    seg_decode = 7'h6f;
            default: seg_decode = 7'h00;
        endcase
    endfunction : seg_decode

    function automatic logic [7:0] one_hot(input logic [2:0] p);
        one_hot = 8'h01 << p;
    endfunction : one_hot

    // ****************************************************************
    // shift rate divider
    // ****************************************************************
    logic [7:0] div_r;
    logic       shift_en;

    assign shift_en = (div_r == 8'(SHIFT_DIV - 1));

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            div_r <= 8'h00;
        end else if (shift_en) begin
            div_r <= 8'h00;
        end else begin
            div_r <= div_r + 8'h01; // R18
        end
    end

    a_div_ten: assert property (@(posedge ref_clk) disable iff (rst)
        shift_en |=> !shift_en [*8]) // R18
        else $error("shift enable came early");

    generate
        if (VARIANT == VAR_DIGIT) begin : g_digit
            // ********************************************************
            // digit-serial planes and adder
            // ********************************************************
            bcd_t       digit;
            bcd_t       top;
            bcd_t       step;
            bcd_t       sum;
            bcd_t       wb;
            logic       corr;
            logic       sum_bit_one;
            logic       sum_bit_two;
            logic [2:0] pos_r;
            logic       carry_r;
            logic       busy_r;
            logic [1:0] edge_r;
            logic       rise;

            for (genvar g = 0; g < `PLANE_COUNT; g++) begin : g_plane
                logic [`DIGIT_COUNT-1:0] sh_r;
                assign digit[g] = sh_r[0];
                assign top[g]   = sh_r[`DIGIT_COUNT-1];
                always_ff @(posedge ref_clk) begin
                    if (rst) begin
                        sh_r <= 8'h00; // R19
                    end else if (shift_en) begin
                        sh_r <= {wb[g], sh_r[`DIGIT_COUNT-1:1]}; // R1
                    end
                end
            end

            assign step        = count_up ? `UP_STEP : `DOWN_STEP;
            assign sum         = digit + (carry_r ? step : 4'h0); // R4
            // weight-8 output; with weight 2 only 10 or 15 reach here
            assign sum_bit_one = sum[1];
            assign sum_bit_two = sum[3];
            assign corr        = carry_r & sum_bit_one & sum_bit_two; // R6
            assign wb          = corr ? (count_up ? `UP_LOAD : `DOWN_LOAD)
                                      : sum; // R2 R5 R7

            // ********************************************************
            // position, carry, request
            // ********************************************************
            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    pos_r <= 3'h0; // R19
                end else if (shift_en) begin
                    pos_r <= pos_r + 3'h1; // R8
                end
            end

            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    carry_r <= 1'b0;
                end else if (shift_en) begin
                    // overflow past the top digit is dropped here
                    carry_r <= (pos_r == `LAST_POS) ? busy_r : corr; // R3 R5
                end
            end

            assign rise = edge_r[0] & ~edge_r[1]; // R10

            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    edge_r <= 2'h0;
                end else begin
                    edge_r <= {edge_r[0], count_in}; // R10
                end
            end

            // a new edge beats the consume in the same cycle
            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    busy_r <= 1'b0;
                end else if (rise) begin
                    busy_r <= 1'b1; // R11
                end else if (shift_en && pos_r == `LAST_POS) begin
                    busy_r <= 1'b0; // R11
                end
            end

            assign busy = busy_r;

            // ********************************************************
            // display scan
            // ********************************************************
            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    digit_sel_r <= 8'h00;
                    seg_r       <= 7'h00;
                end else if (shift_en) begin
                    digit_sel_r <= one_hot(pos_r); // R8
                    seg_r       <= seg_decode(digit); // R9
                end
            end

            a_edge_busy: assert property (@(posedge ref_clk) disable iff (rst)
                rise |=> busy_r) // R10
                else $error("edge did not raise busy");

            a_busy_held: assert property (@(posedge ref_clk) disable iff (rst)
                busy_r && !(shift_en && pos_r == `LAST_POS) |=> busy_r) // R11
                else $error("busy dropped before use");

            a_carry_preset: assert property (@(posedge ref_clk)
                disable iff (rst)
                shift_en && pos_r == `LAST_POS && busy_r
                |=> carry_r && pos_r == 3'h0) // R3
                else $error("carry not preset at low digit");

            a_up_wrap: assert property (@(posedge ref_clk) disable iff (rst)
                shift_en && carry_r && count_up && digit == 4'h9
                && pos_r != `LAST_POS |=> top == 4'h0 && carry_r) // R5
                else $error("up wrap wrong");

            a_down_wrap: assert property (@(posedge ref_clk) disable iff (rst)
                shift_en && carry_r && !count_up && digit == 4'h0
                && pos_r != `LAST_POS |=> top == 4'h9 && carry_r) // R7
                else $error("down wrap wrong");

            a_add_one: assert property (@(posedge ref_clk) disable iff (rst)
                shift_en && carry_r && count_up && digit < 4'h9
                |=> top == $past(digit) + 4'h1) // R4
                else $error("increment wrong");

            a_add_fifteen: assert property (@(posedge ref_clk)
                disable iff (rst)
                shift_en && carry_r && !count_up && digit > 4'h0
                |=> top == $past(digit) - 4'h1) // R4
                else $error("decrement wrong");

            a_plain_pass: assert property (@(posedge ref_clk) disable iff (rst)
                shift_en && !carry_r |=> top == $past(digit)) // R2
                else $error("digit altered without carry");

            a_scan_select: assert property (@(posedge ref_clk)
                disable iff (rst)
                shift_en |=> digit_sel_r == one_hot($past(pos_r))
                && pos_r == $past(pos_r) + 3'h1) // R8
                else $error("digit select off position");

            a_seg_decode: assert property (@(posedge ref_clk) disable iff (rst)
                shift_en |=> seg_r == seg_decode($past(digit))) // R9
                else $error("segments not from digit");

            a_reset_clear: assert property (@(posedge ref_clk)
                rst |=> pos_r == 3'h0 && !busy_r && !carry_r
                && edge_r == 2'h0 && digit == 4'h0) // R19
                else $error("reset left state");
        end else begin : g_bit
            // ********************************************************
            // bit-serial stopwatch counter
            // ********************************************************
            logic [`BIT_LEN-1:0] cnt_r;
            logic [`BIT_LEN-1:0] store_r;
            logic [5:0]          bit_r;
            logic [3:0]          dig;
            logic                start;
            bcd_t                limit;
            logic                c_bit;
            logic                c_bit_r;
            logic                wrap;
            logic                wrap_r;
            logic                dcarry_r;
            logic                new_bit;
            bcd_t                hold_r;

            assign dig   = bit_r[5:2];
            assign start = (bit_r[1:0] == 2'h0);
            assign limit = (dig == `TENS_SEC_DIGIT || dig == `TENS_MIN_DIGIT)
                         ? `SIX_LIMIT : `DEC_LIMIT; // R15
            // the lowest digit always takes the time-base step
            assign c_bit = start ? ((bit_r == 6'h00) | dcarry_r) : c_bit_r;
            assign wrap  = start ? (c_bit & (cnt_r[3:0] == limit)) : wrap_r;
            assign new_bit = wrap ? 1'b0 : (cnt_r[0] ^ c_bit); // R13

            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    bit_r <= 6'h00;
                end else if (shift_en) begin
                    bit_r <= (bit_r == `LAST_BIT) ? 6'h00
                                                  : bit_r + 6'h01; // R14
                end
            end

            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    cnt_r    <= '0;
                    c_bit_r  <= 1'b0;
                    wrap_r   <= 1'b0;
                    dcarry_r <= 1'b0;
                end else if (shift_en) begin
                    cnt_r   <= {new_bit, cnt_r[`BIT_LEN-1:1]}; // R13
                    c_bit_r <= c_bit & cnt_r[0];
                    wrap_r  <= wrap;
                    if (bit_r[1:0] == 2'h3) begin
                        dcarry_r <= wrap; // R15
                    end
                end
            end

            // stop freezes the store while the counter keeps running
            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    store_r <= '0;
                end else if (shift_en) begin
                    store_r <= {stop ? store_r[0] : new_bit,
                                store_r[`BIT_LEN-1:1]}; // R16
                end
            end

            // lowest digit is tenths of a millisecond, never shown
            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    hold_r      <= 4'h0;
                    digit_sel_r <= 8'h00;
                end else if (shift_en && start) begin
                    hold_r      <= store_r[3:0]; // R17
                    digit_sel_r <= (dig == 4'h0) ? 8'h00
                                 : one_hot(3'(dig - 4'h1));
                end
            end

            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    seg_r <= 7'h00;
                end else begin
                    seg_r <= seg_decode(hold_r);
                end
            end

            assign busy = 1'b0;

            a_pass_len: assert property (@(posedge ref_clk) disable iff (rst)
                shift_en && bit_r == `LAST_BIT |=> bit_r == 6'h00) // R14
                else $error("pass is not 36 shifts");

            a_store_hold: assert property (@(posedge ref_clk)
                disable iff (rst)
                shift_en && stop |=> store_r ==
                {$past(store_r[0]), $past(store_r[`BIT_LEN-1:1])}) // R16
                else $error("store moved while stopped");

            a_store_follow: assert property (@(posedge ref_clk)
                disable iff (rst)
                shift_en && !stop |=> store_r[`BIT_LEN-1] ==
                cnt_r[`BIT_LEN-1]) // R16
                else $error("store not following counter");

            a_latch_four: assert property (@(posedge ref_clk)
                disable iff (rst)
                hold_r != $past(hold_r) |-> $past(shift_en)
                && $past(bit_r[1:0]) == 2'h0) // R17
                else $error("holding register changed off slot");

            a_six_wrap: assert property (@(posedge ref_clk) disable iff (rst)
                shift_en && start && dig == `TENS_SEC_DIGIT && c_bit
                && cnt_r[3:0] == 4'h5 |=> wrap_r && !cnt_r[`BIT_LEN-1]) // R15
                else $error("tens of seconds did not wrap at six");
        end
    endgenerate

endmodule : serial_bcd_updown_counter

// [verification/count_src_disp.sv]
// partner model: asynchronous count source and display capture
`timescale 1ns/10ps

module count_src_disp
    import serial_bcd_pkg::*;
#(
    parameter int unsigned SHIFT_DIV = 10
) (
    input  wire logic       ref_clk,
    input  wire logic       busy,
    input  wire logic [7:0] digit_sel_r,
    input  wire seg_t       seg_r,
    output logic            count_in,
    output logic            count_up
);
    seg_t shown [8];
    logic busy_seen;
    logic prev_in;

    initial begin
        count_in = 1'b0;
        prev_in = 1'b0;
        count_up = 1'b1;
        busy_seen = 1'b0;
        for (int i = 0; i < 8; i++) begin
            shown[i] = 7'h00;
        end
    end

    // ****************************************************************
    // display side: keep the last pattern of each selected digit
    // ****************************************************************
    // busy_seen has one driver: cleared at our own count edge
    always @(posedge ref_clk) begin
        prev_in <= count_in;
        if (busy === 1'b1) begin
            busy_seen <= 1'b1;
        end else if (count_in === 1'b1 && prev_in === 1'b0) begin
            busy_seen <= 1'b0;
        end
        for (int i = 0; i < 8; i++) begin
            if (digit_sel_r[i] === 1'b1) begin
                shown[i] <= seg_r;
            end
        end
    end

    // ****************************************************************
    // count side: one edge, then 17 shifts of quiet
    // ****************************************************************
    // direction held until the consume and its 8 writes are over
    task automatic step(input logic up);
        count_up <= up;
        @(posedge ref_clk);
        count_in <= 1'b1;
        repeat (SHIFT_DIV * 4) @(posedge ref_clk);
        count_in <= 1'b0;
        repeat (SHIFT_DIV * 13) @(posedge ref_clk);
    endtask : step
endmodule : count_src_disp

// [verification/serial_bcd_updown_counter_tb_top.sv]
// self-checking bench for the digit-serial bcd up/down counter
`timescale 1ns/10ps

module serial_bcd_updown_counter_tb_top
    import serial_bcd_pkg::*;
    ;
    localparam int unsigned DIV = 10;

    logic       ref_clk;
    logic       rst;
    logic       stop;
    logic       count_in;
    logic       count_up;
    logic       busy;
    logic [7:0] digit_sel_r;
    seg_t       seg_r;
    logic [7:0] sw_sel;
    seg_t       sw_seg;
    seg_t       seg_a;
    seg_t       seg_b;
    bcd_t       model [8];
    int         err_total;
    int         compares;
    int         cyc;

    serial_bcd_updown_counter #(
        .VARIANT   (VAR_DIGIT),
        .SHIFT_DIV (DIV)
    ) u_serial_bcd_updown_counter (
        .ref_clk     (ref_clk),
        .rst         (rst),
        .count_in    (count_in),
        .count_up    (count_up),
        .stop        (stop),
        .busy        (busy),
        .digit_sel_r (digit_sel_r),
        .seg_r       (seg_r)
    );

    count_src_disp #(
        .SHIFT_DIV (DIV)
    ) u_count_src_disp (
        .ref_clk     (ref_clk),
        .busy        (busy),
        .digit_sel_r (digit_sel_r),
        .seg_r       (seg_r),
        .count_in    (count_in),
        .count_up    (count_up)
    );

    // stopwatch variant runs beside the digit counter
    serial_bcd_updown_counter #(
        .VARIANT   (VAR_BIT),
        .SHIFT_DIV (DIV)
    ) u_serial_bcd_updown_counter_sw (
        .ref_clk     (ref_clk),
        .rst         (rst),
        .count_in    (count_in),
        .count_up    (count_up),
        .stop        (stop),
        .busy        (),
        .digit_sel_r (sw_sel),
        .seg_r       (sw_seg)
    );

    // ****************************************************************
    // expectations
    // ****************************************************************
    function automatic seg_t seg_of(input bcd_t d);
        case (d)
            4'h0: return 7'h3f;
            4'h1: return 7'h06;
            4'h2: return 7'h5b;
            4'h3: return 7'h4f;
            4'h4: return 7'h66;
            4'h5: return 7'h6d;
            4'h6: return 7'h7d;
            4'h7: return 7'h07;
            4'h8: return 7'h7f;
            4'h9: return 7'h6f;
            default: return 7'h00;
        endcase
    endfunction : seg_of

    // ripple through all eight digits; overflow of the top is lost
    function automatic void bump(input logic up);
        for (int i = 0; i < 8; i++) begin
            if (up && model[i] == 4'h9) begin
                model[i] = 4'h0;
            end else if (!up && model[i] == 4'h0) begin
                model[i] = 4'h9;
            end else begin
                model[i] = up ? model[i] + 4'h1 : model[i] - 4'h1;
                break;
            end
        end
    endfunction : bump

    // ****************************************************************
    // compare and report
    // ****************************************************************
    task automatic chk_seg(input seg_t got, input seg_t exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_seg

    task automatic chk_bit(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_bit

    task automatic finish_test;
        $display("compares %0d errors %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : finish_test

    task automatic chk_display;
        repeat (DIV * 10) @(posedge ref_clk);
        chk_bit($onehot(digit_sel_r), 1'b1);
        for (int i = 0; i < 8; i++) begin
            chk_seg(u_count_src_disp.shown[i], seg_of(model[i]));
        end
    endtask : chk_display

    // segments of the millisecond digit while it is selected
    task automatic sw_digit(output seg_t s);
        int n;
        n = 0;
        while (sw_sel[0] !== 1'b1 && n < 800) begin
            @(posedge ref_clk);
            n++;
        end
        if (n >= 800) begin
            err_total++;
            finish_test();
        end
        repeat (2) @(posedge ref_clk);
        s = sw_seg;
    endtask : sw_digit

    task automatic do_step(input logic up);
        u_count_src_disp.step(up);
        bump(up);
        chk_bit(u_count_src_disp.busy_seen, 1'b1);
        chk_bit(busy, 1'b0);
        chk_display();
    endtask : do_step

    task automatic do_reset;
        rst <= 1'b1;
        repeat (10) @(posedge ref_clk);
        chk_bit(busy, 1'b0);
        chk_seg(seg_r, 7'h00);
        chk_bit(|digit_sel_r, 1'b0);
        rst <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            model[i] = 4'h0;
        end
        chk_display();
    endtask : do_reset

    // ****************************************************************
    // clock, watchdog, sequence
    // ****************************************************************
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    // a run that outgrows its budget is a hang
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc > 100000) begin
            err_total++;
            finish_test();
        end
    end

    initial begin
        rst = 1'b1;
        stop = 1'b0;
        err_total = 0;
        compares = 0;
        cyc = 0;
        void'($urandom(32'h7f209ccd));
        @(posedge ref_clk);
        do_reset();
        $display("test reset done");
        stop <= 1'b1;
        repeat (400) @(posedge ref_clk);
        sw_digit(seg_a);
        repeat (3600) @(posedge ref_clk);
        sw_digit(seg_b);
        chk_seg(seg_b, seg_a);
        stop <= 1'b0;
        repeat (800) @(posedge ref_clk);
        sw_digit(seg_b);
        chk_bit(seg_b != seg_a, 1'b1);
        $display("test stopwatch done");
        do_step(1'b0);
        do_step(1'b1);
        $display("test wrap done");
        for (int n = 0; n < 11; n++) begin
            do_step(1'b1);
        end
        for (int n = 0; n < 11; n++) begin
            do_step(1'b0);
        end
        $display("test carry done");
        for (int n = 0; n < 30; n++) begin
            do_step(1'($urandom_range(1, 0)));
        end
        $display("test random done");
        u_count_src_disp.step(1'b1);
        do_reset();
        $display("test second reset done");
        finish_test();
    end
endmodule : serial_bcd_updown_counter_tb_top
